// [crc_wdt_defs.svh]
// Register map, field positions, reset values and timing constants of the register group
`ifndef CRC_WDT_DEFS_SVH
`define CRC_WDT_DEFS_SVH

// ==========================================================================
// Byte addresses
`define ADDR_VER_LO     16'hffee
`define ADDR_VER_HI     16'hffef
`define ADDR_WDT_LO     16'hfff0
`define ADDR_WDT_HI     16'hfff1
`define ADDR_START_LO   16'hfff2
`define ADDR_START_HI   16'hfff3
`define ADDR_LEN_LO     16'hfff4
`define ADDR_LEN_HI     16'hfff5
`define ADDR_RES_LO     16'hfff6
`define ADDR_RES_HI     16'hfff7
`define ADDR_IFLAG_LO   16'hfff8
`define ADDR_IFLAG_HI   16'hfff9
`define ADDR_IEN_LO     16'hfffa
`define ADDR_IEN_HI     16'hfffb
`define ADDR_STAT_LO    16'hfffc
`define ADDR_STAT_HI    16'hfffd

// ==========================================================================
// Field positions and reset values
`define BIT_WDT_EN      0
`define BIT_WDT_SEL_LSB 1
`define BIT_IRQ_CRC     3
`define BIT_STAT_ACTIVE 1
`define RST_BYTE        8'h00
`define RST_WORD        16'h0000
`define WDT_SEL_2S      3'h0
`define WDT_SEL_32S     3'h1
`define WDT_SEL_510S    3'h2

// ==========================================================================
// Checksum constants
`define CRC_SEED        16'hffff
`define CRC_POLY        16'h1021

// ==========================================================================
// Timing: clock, low-frequency oscillator and watchdog periods
`define CLK_HZ          50000000
`define LF_HZ           256000
`define WDT_T0_S        2
`define WDT_T1_S        32
`define WDT_T2_MS       510000
`define LF_PER_MS       (`LF_HZ / 1000)

`endif

// [crc_wdt_pkg.sv]
// Types shared by the checksum and watchdog register group
`default_nettype none
package crc_wdt_pkg;
  // Gray order along idle -> fetch -> calc -> done -> idle
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_CALC  = 2'b11,
    ST_DONE  = 2'b10
  } crc_state_e;
endpackage
`default_nettype wire

// [crc_watchdog_version_regs.sv]
// Checksum engine, communication watchdog and version registers behind the byte register port
// Function
// - Compute a 16-bit checksum over the programmed message-memory range.
// - Writing the length high byte launches; other byte writes only store.
// - Length is an even byte count, bit 0 ignored; read/write, resets to zero.
// - Start address is a memory offset, bit 0 ignored; read/write, resets to zero.
// - Active indication is one while a computation runs, zero afterwards.
// - Completion sets the done flag and shows the result, low byte lower.
// - Polynomial x^16+x^12+x^5+1, accumulator seeded with all ones.
// - Watchdog enable bit 0: zero disables, one enables; resets disabled.
// - Enabled watchdog resets the device when no access arrives in time.
// - In parity mode only transfers that pass their check restart the watchdog.
// - Timeout select bits 3..1: 2 s, 32 s, 8.5 min; others reserved.
// - Watchdog periods count cycles of the 256 kHz low-frequency oscillator.
// - Version register: identification in bits 7..0, revision in bits 15..8.
// - Enabled interrupt flags are ORed onto one interrupt pin.
// - Done flag is bit 3; writing one clears it, zero leaves it.
// - Active indication is bit 1 of the read-only status register.
`include "crc_wdt_defs.svh"
`default_nettype none

module crc_watchdog_version_regs #(
  parameter int          MEM_AW     = 16,
  parameter int          LF_DIV     = `CLK_HZ / `LF_HZ,
  parameter int          WDT_CW     = 27,
  parameter int          WDT_LIM0   = `WDT_T0_S * `LF_HZ,
  parameter int          WDT_LIM1   = `WDT_T1_S * `LF_HZ,
  parameter int          WDT_LIM2   = `WDT_T2_MS * `LF_PER_MS,
  parameter logic [7:0]  FW_ID      = 8'h5a,  // Arbitrary identification value
  parameter logic [7:0]  FW_REV     = 8'h03   // Arbitrary revision value
) (
  input  wire logic               ref_clk,
  input  wire logic               resetn,
  input  wire logic [15:0]        reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output var  logic [7:0]         reg_rdata,
  input  wire logic               xfer_done,
  input  wire logic               xfer_ok,
  input  wire logic               parity_mode,
  output var  logic [MEM_AW-1:0]  mem_addr,
  output var  logic               mem_rd_en,
  input  wire logic [7:0]         mem_rdata,
  output var  logic               int_out,
  output var  logic               wdt_reset
);
  import crc_wdt_pkg::*;

  // ==========================================================================
  // Elaboration checks
  if (LF_DIV < 1 || LF_DIV > 256 || MEM_AW < 2 || MEM_AW > 16) begin : g_bad_size
    $error("crc_watchdog_version_regs: bad divider or memory address width");
  end
  if (WDT_LIM0 < 1 || WDT_LIM1 < 1 || WDT_LIM2 < 1 || WDT_CW > 31 ||
      WDT_LIM2 >= (1 << WDT_CW) || WDT_LIM1 >= (1 << WDT_CW) ||
      WDT_LIM0 >= (1 << WDT_CW)) begin : g_bad_wdt
    $error("crc_watchdog_version_regs: watchdog limits do not fit the counter");
  end

  // One bit-serial pass over a byte, msb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (r[15] ^ d[i]) begin
        r = {r[14:0], 1'b0} ^ `CRC_POLY;
      end else begin
        r = {r[14:0], 1'b0};
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // Register storage
  logic [15:0]       start_addr;
  logic [15:0]       len;
  logic [15:0]       result;
  logic              wdt_en;
  logic [2:0]        wdt_sel;
  logic              irq_en_crc;
  logic              flag_crc;
  logic              busy;
  crc_state_e        state;
  crc_state_e        next_state;
  logic [15:0]       crc;
  logic [15:0]       remaining;
  logic [MEM_AW-1:0] cur_addr;

  // Address decode
  wire wr_start_lo = reg_wr && reg_addr == `ADDR_START_LO;
  wire wr_start_hi = reg_wr && reg_addr == `ADDR_START_HI;
  wire wr_len_lo   = reg_wr && reg_addr == `ADDR_LEN_LO;
  wire launch      = reg_wr && reg_addr == `ADDR_LEN_HI;
  wire wr_wdt      = reg_wr && reg_addr == `ADDR_WDT_LO;
  wire wr_ien      = reg_wr && reg_addr == `ADDR_IEN_LO;
  wire wr_iflag    = reg_wr && reg_addr == `ADDR_IFLAG_LO;
  wire clr_crc     = wr_iflag && reg_wdata[`BIT_IRQ_CRC];
  wire set_crc     = state == ST_DONE && !launch;             // Aborted runs stay silent
  // Bit 0 is dropped on both values so the range is whole 16-bit words
  wire [15:0] new_len   = {reg_wdata, len[7:1], 1'b0};
  wire [15:0] even_base = {start_addr[15:1], 1'b0};

  // Byte register writes; the length high byte is stored by the launch itself
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      start_addr <= `RST_WORD;
      len        <= `RST_WORD;
      wdt_en     <= 1'b0;
      wdt_sel    <= `WDT_SEL_2S;
      irq_en_crc <= 1'b0;
    end else begin
      if (wr_start_lo) start_addr[7:0]  <= reg_wdata;
      if (wr_start_hi) start_addr[15:8] <= reg_wdata;
      if (wr_len_lo)   len[7:0]         <= reg_wdata;
      if (launch)      len[15:8]        <= reg_wdata;
      if (wr_wdt) begin
        wdt_en  <= reg_wdata[`BIT_WDT_EN];
        wdt_sel <= reg_wdata[`BIT_WDT_SEL_LSB +: 3];
      end
      if (wr_ien) irq_en_crc <= reg_wdata[`BIT_IRQ_CRC];
    end
  end

  // ==========================================================================
  // Checksum engine: fetch a byte, fold it in, step upward
  always_comb begin
    case (state)
      ST_IDLE:  next_state = ST_IDLE;
      ST_FETCH: next_state = ST_CALC;
      ST_CALC:  next_state = (remaining == 16'h0001) ? ST_DONE : ST_FETCH;
      ST_DONE:  next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
    // A launch always wins, even mid-run; empty ranges finish at once
    if (launch) begin
      next_state = (new_len == `RST_WORD) ? ST_DONE : ST_FETCH;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state     <= ST_IDLE;
      crc       <= `CRC_SEED;
      remaining <= `RST_WORD;
      cur_addr  <= '0;
      mem_addr  <= '0;
      mem_rd_en <= 1'b0;
      result    <= `RST_WORD;
      busy      <= 1'b0;
    end else begin
      state     <= next_state;
      mem_rd_en <= next_state == ST_FETCH;
      if (launch) begin
        crc       <= `CRC_SEED;
        remaining <= new_len;
        cur_addr  <= even_base[MEM_AW-1:0];
        mem_addr  <= even_base[MEM_AW-1:0];
        busy      <= 1'b1;
      end else if (state == ST_CALC) begin
        // Memory answers one cycle after the read strobe
        crc       <= crc_byte(crc, mem_rdata);
        remaining <= remaining - 16'h0001;
        cur_addr  <= cur_addr + 1'b1;
        mem_addr  <= cur_addr + 1'b1;
      end else if (state == ST_DONE) begin
        result <= crc;
        busy   <= 1'b0;
      end
    end
  end

  // Done flag: a completion in the clearing cycle is kept
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flag_crc <= 1'b0;
      int_out  <= 1'b0;
    end else begin
      if (set_crc)      flag_crc <= 1'b1;
      else if (clr_crc) flag_crc <= 1'b0;
      int_out <= flag_crc && irq_en_crc;
    end
  end

  // ==========================================================================
  // Communication watchdog on low-frequency ticks
  logic [7:0]        lf_cnt;
  logic              lf_tick;
  logic [WDT_CW-1:0] wdt_cnt;
  logic [WDT_CW-1:0] wdt_lim;
  wire kick = xfer_done && (!parity_mode || xfer_ok);

  // Reserved selections fall back to the longest period
  always_comb begin
    case (wdt_sel)
      `WDT_SEL_2S:  wdt_lim = WDT_CW'(WDT_LIM0);
      `WDT_SEL_32S: wdt_lim = WDT_CW'(WDT_LIM1);
      default:      wdt_lim = WDT_CW'(WDT_LIM2);
    endcase
  end

  // Oscillator tick from the fast clock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lf_cnt  <= 8'h00;
      lf_tick <= 1'b0;
    end else begin
      lf_tick <= lf_cnt == 8'(LF_DIV - 1);
      lf_cnt  <= (lf_cnt == 8'(LF_DIV - 1)) ? 8'h00 : lf_cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wdt_cnt   <= '0;
      wdt_reset <= 1'b0;
    end else begin
      wdt_reset <= 1'b0;
      if (!wdt_en || kick) begin
        wdt_cnt <= '0;
      end else if (lf_tick) begin
        if (wdt_cnt >= wdt_lim - 1'b1) begin
          wdt_cnt   <= '0;
          wdt_reset <= 1'b1;
        end else begin
          wdt_cnt <= wdt_cnt + 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Read path: data one cycle after the strobe, zero when unmapped
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `ADDR_VER_LO:   rd_mux = FW_ID;
      `ADDR_VER_HI:   rd_mux = FW_REV;
      `ADDR_WDT_LO:   rd_mux = {4'h0, wdt_sel, wdt_en};
      `ADDR_START_LO: rd_mux = start_addr[7:0];
      `ADDR_START_HI: rd_mux = start_addr[15:8];
      `ADDR_LEN_LO:   rd_mux = len[7:0];
      `ADDR_LEN_HI:   rd_mux = len[15:8];
      `ADDR_RES_LO:   rd_mux = result[7:0];
      `ADDR_RES_HI:   rd_mux = result[15:8];
      `ADDR_IFLAG_LO: rd_mux = 8'(flag_crc) << `BIT_IRQ_CRC;
      `ADDR_IEN_LO:   rd_mux = 8'(irq_en_crc) << `BIT_IRQ_CRC;
      `ADDR_STAT_LO:  rd_mux = 8'(busy) << `BIT_STAT_ACTIVE;
      default:        rd_mux = `RST_BYTE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) reg_rdata <= `RST_BYTE;
    else if (reg_rd) reg_rdata <= rd_mux;
  end

  // ==========================================================================
  // Checks
  sequence s_fetch_calc;
    state == ST_FETCH ##1 state == ST_CALC;
  endsequence

  property p_launch;
    @(posedge ref_clk) disable iff (!resetn)
      launch |=> busy && crc == `CRC_SEED;
  endproperty
  a_launch: assert property (p_launch) else $error("launch did not seed");

  property p_lo_store;
    @(posedge ref_clk) disable iff (!resetn)
      (wr_len_lo && !busy) |=> !busy && state == ST_IDLE;
  endproperty
  a_lo_store: assert property (p_lo_store) else $error("low byte launched");

  property p_even_base;
    @(posedge ref_clk) disable iff (!resetn)
      launch |=> !mem_addr[0] && !remaining[0];
  endproperty
  a_even_base: assert property (p_even_base) else $error("odd base or length");

  property p_step;
    @(posedge ref_clk) disable iff (!resetn)
      (s_fetch_calc ##0 !launch) |=> mem_addr == $past(mem_addr) + 1'b1;
  endproperty
  a_step: assert property (p_step) else $error("address not ascending");

  property p_done;
    @(posedge ref_clk) disable iff (!resetn)
      state == ST_DONE && !launch |=> flag_crc && !busy && result == $past(crc);
  endproperty
  a_done: assert property (p_done) else $error("completion not reported");

  property p_active;
    @(posedge ref_clk) disable iff (!resetn)
      (state == ST_FETCH || state == ST_CALC) |-> busy;
  endproperty
  a_active: assert property (p_active) else $error("active bit low mid-run");

  property p_irq;
    @(posedge ref_clk) disable iff (!resetn)
      !irq_en_crc |=> !int_out;
  endproperty
  a_irq: assert property (p_irq) else $error("disabled flag drove pin");

  property p_clear;
    @(posedge ref_clk) disable iff (!resetn)
      clr_crc && !set_crc |=> !flag_crc ##1 !int_out;
  endproperty
  a_clear: assert property (p_clear) else $error("flag clear failed");

  property p_bad_xfer;
    @(posedge ref_clk) disable iff (!resetn)
      (parity_mode && xfer_done && !xfer_ok && wdt_en && !lf_tick && wdt_cnt != '0)
      |=> wdt_cnt == $past(wdt_cnt);
  endproperty
  a_bad_xfer: assert property (p_bad_xfer) else $error("bad transfer kicked");

  property p_wdt_off;
    @(posedge ref_clk) disable iff (!resetn)
      !wdt_en |=> !wdt_reset && wdt_cnt == '0;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("disabled watchdog fired");

  property p_version;
    @(posedge ref_clk) disable iff (!resetn)
      reg_rd && reg_addr == `ADDR_VER_LO |=> reg_rdata == FW_ID;
  endproperty
  a_version: assert property (p_version) else $error("wrong identification");

endmodule
`default_nettype wire

// [crc_msg_mem_model.sv]
// Message memory model that answers the checksum engine's byte reads
`default_nettype none

module crc_msg_mem_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd_en,
  output var  logic [7:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Read port
  // One cycle latency; outside a read slot the bus toggles so stale data never matches
  always @(posedge ref_clk) begin
    mem_rdata <= mem_rd_en ? (mem_addr[7:0] ^ 8'ha5) : ~mem_rdata;
  end
endmodule

`default_nettype wire

// [crc_watchdog_version_regs_tb.sv]
// Self-checking testbench for the checksum, watchdog and version register group
`default_nettype none

module crc_watchdog_version_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Short watchdog counts keep the run small
  localparam int         DIV = 2;
  localparam int         L0  = 3;
  localparam int         L1  = 5;
  localparam int         L2  = 7;
  localparam logic [7:0] ID  = 8'h3c;  // Arbitrary identification value
  localparam logic [7:0] REV = 8'h7e;  // Arbitrary revision value

  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        xfer_done = 1'b0;
  logic        xfer_ok = 1'b0;
  logic        parity_mode = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic [7:0]  mem_rdata;
  logic [15:0] mem_addr;
  logic        mem_rd_en;
  logic        int_out;
  logic        wdt_reset;
  int          n_errors = 0;
  int          comparisons = 0;
  int          pulses = 0;

  always #10 ref_clk = ~ref_clk;
  // Count watchdog requests as they leave the block
  always @(posedge ref_clk) begin
    if (wdt_reset === 1'b1) pulses <= pulses + 1;
  end

  crc_watchdog_version_regs #(.LF_DIV(DIV), .WDT_LIM0(L0), .WDT_LIM1(L1), .WDT_LIM2(L2),
    .FW_ID(ID), .FW_REV(REV)) DUT (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .xfer_done(xfer_done), .xfer_ok(xfer_ok), .parity_mode(parity_mode),
    .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_rdata(mem_rdata),
    .int_out(int_out), .wdt_reset(wdt_reset));

  crc_msg_mem_model mem (.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
    .mem_rdata(mem_rdata));

  // ==========================================================================
  // Shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Bus requests start 1 ns after an edge and drop after the edge that takes them;
  // one idle edge follows so a strobe never rises in the step that lowers it
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1 reg_wr = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1 reg_rd = 1'b0;
    d = reg_rdata;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic rd16(input logic [15:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 16'h0001, v[15:8]);
  endtask

  // Reference checksum over the memory model's byte pattern, msb first
  function automatic logic [15:0] crc_ref(input logic [15:0] s, input logic [15:0] n);
    logic [15:0] c = 16'hffff;
    logic [7:0]  b;
    for (int i = 0; i < int'(n & 16'hfffe); i++) begin
      b = 8'((s & 16'hfffe) + 16'(i)) ^ 8'ha5;
      for (int j = 7; j >= 0; j--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ b[j]) ? 16'h1021 : 16'h0000);
      end
    end
    return c;
  endfunction

  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    logic [15:0] v;
    logic [15:0] ra [6] = '{16'hfff0, 16'hfff2, 16'hfff4, 16'hfff6, 16'hfff8, 16'hfffc};
    foreach (ra[i]) begin
      rd16(ra[i], v);
      check("reset value", v, 16'h0000);
    end
    rd16(16'hffee, v);
    check("version", v, {REV, ID});
    wr(16'hffee, 8'h11);
    rd16(16'hffee, v);
    check("version read only", v, {REV, ID});
    wr(16'hfff2, 8'ha7);
    wr(16'hfff3, 8'h12);
    rd16(16'hfff2, v);
    check("start address", v, 16'h12a7);
    wr(16'hfff6, 8'h55);
    rd16(16'hfff6, v);
    check("result read only", v, 16'h0000);
    wr(16'hfff0, 8'hfd);
    rd16(16'hfff0, v);
    check("watchdog control", v, 16'h000d);
    wr(16'hfff0, 8'hf0);
    wr(16'hfff1, 8'hff);
    rd16(16'hfff0, v);
    check("watchdog reserved", v, 16'h0000);
    rd(16'h0100, v[7:0]);
    check("unmapped", {8'h00, v[7:0]}, 16'h0000);
  endtask

  // Program a range, launch on the high length byte and judge result, flag and pin;
  // mid says an earlier computation is still running when the range is programmed
  task automatic t_crc(input logic [15:0] s, input logic [15:0] n, input logic ie,
                       input logic mid);
    logic [15:0] v;
    int          k;
    wr(16'hfff2, s[7:0]);
    wr(16'hfff3, s[15:8]);
    wr(16'hfff4, n[7:0]);
    rd(16'hfffc, v[7:0]);
    check("status before launch", {8'h00, v[7:0]}, {14'h0, mid, 1'b0});
    wr(16'hfff5, n[15:8]);
    rd(16'hfffc, v[7:0]);
    if (n > 16'h0003) check("active", {8'h00, v[7:0]}, 16'h0002);
    for (k = 0; k < 300; k++) begin
      rd(16'hfff8, v[7:0]);
      if (v[3] === 1'b1) break;
    end
    if (k == 300) begin
      check("done flag timeout", 16'h0000, 16'h0001);
      conclude();
    end
    rd16(16'hfff6, v);
    check("result", v, crc_ref(s, n));
    rd(16'hfffc, v[7:0]);
    check("active after done", {8'h00, v[7:0]}, 16'h0000);
    check("interrupt pin", {15'h0, int_out}, {15'h0, ie});
    wr(16'hfff8, 8'h00);
    rd(16'hfff8, v[7:0]);
    check("flag kept", {8'h00, v[7:0]}, 16'h0008);
    wr(16'hfff8, 8'h08);
    rd(16'hfff8, v[7:0]);
    check("flag cleared", {8'h00, v[7:0]}, 16'h0000);
    check("pin cleared", {15'h0, int_out}, 16'h0000);
  endtask

  task automatic wait_wdt(input int bound, output int n);
    n = 0;
    while (n < bound && wdt_reset !== 1'b1) begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask

  task automatic kicks(input logic par, input logic ok, output int got);
    int p;
    p = pulses;
    parity_mode = par;
    xfer_ok = ok;
    repeat (12) begin
      xfer_done = 1'b1;
      @(posedge ref_clk);
      #1 xfer_done = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
    end
    got = pulses - p;
  endtask

  task automatic t_wdt;
    int         n;
    int         e;
    logic [2:0] sel [4] = '{3'h0, 3'h1, 3'h2, 3'h7};
    int         lim [4] = '{L0, L1, L2, L2};
    wait_wdt(40, n);
    check("watchdog disabled", 16'(n), 16'h0028);
    foreach (sel[i]) begin
      wr(16'hfff0, 8'h00);
      wr(16'hfff0, {4'h0, sel[i], 1'b1});
      wait_wdt(100, n);
      e = lim[i] * DIV;
      check("watchdog period", 16'(n >= e - 3 && n <= e + 3), 16'h0001);
      if (n >= 100) conclude();
    end
    wr(16'hfff0, 8'h00);
    wr(16'hfff0, 8'h03);
    kicks(1'b0, 1'b0, n);
    check("kicks plain mode", 16'(n), 16'h0000);
    kicks(1'b1, 1'b1, n);
    check("kicks passing parity", 16'(n), 16'h0000);
    kicks(1'b1, 1'b0, n);
    check("kicks failing parity", 16'(n > 0), 16'h0001);
    wr(16'hfff0, 8'h00);
    parity_mode = 1'b0;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 resetn = 1'b1;
    t_regs();
    t_crc(16'h0010, 16'h0008, 1'b0, 1'b0);
    wr(16'hfffa, 8'h08);
    t_crc(16'h0023, 16'h0007, 1'b1, 1'b0);
    t_crc(16'h0040, 16'h0000, 1'b1, 1'b0);
    t_crc(16'h0040, 16'h0001, 1'b1, 1'b0);
    wr(16'hfff4, 8'h40);
    wr(16'hfff5, 8'h00);
    // Relaunch mid-run with a new range: only the second result may appear
    t_crc(16'h0002, 16'h000a, 1'b1, 1'b1);
    t_wdt();
    conclude();
  end
endmodule

`default_nettype wire
